// file: hdl/sbb_pkg.sv
// constants shared by the stuck bus buffer control logic
package sbb_pkg;

   // system clock rate, in kHz to keep products below 2^31
   localparam int CLK_KHZ        = 25000;

   // bus-idle qualification and enable-to-connect delay, typical 95 us
   localparam int IDLE_TIME_US   = 95;
   localparam int IDLE_CYC       = (IDLE_TIME_US * CLK_KHZ) / 1000;

   // stuck-low timeout, typical 30 ms
   localparam int TIMEOUT_MS     = 30;
   localparam int TIMEOUT_CYC    = TIMEOUT_MS * CLK_KHZ;

   // least gap between a timeout disconnect and the first recovery pulse
   localparam int GAP_TIME_US    = 40;
   localparam int GAP_CYC        = (GAP_TIME_US * CLK_KHZ + 999) / 1000;

   // recovery clock, typical 8.5 kHz; half period rounded down
   localparam int REC_FREQ_HZ    = 8500;
   localparam int REC_HALF_CYC   = (CLK_KHZ * 1000) / (2 * REC_FREQ_HZ);
   localparam int REC_PULSES     = 16;

   // cycles our own released drive is ignored while its pin settles through the syncs
   localparam int HOLD_CYC       = 15;

   // width of the short interval counters
   localparam int CNT_W          = 12;

   // connection states
   typedef enum logic [2:0] {
      SBB_LOCK      = 3'h0,
      SBB_WAIT_BUS  = 3'h1,
      SBB_WAIT_CARD = 3'h2,
      SBB_CONN      = 3'h3,
      SBB_GAP       = 3'h4,
      SBB_RECOVER   = 3'h5
   } sbb_state_t;

endpackage

// file: hdl/sbb_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module sbb_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);

   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second; released lines read high at reset
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_q <= {WIDTH{1'b1}};
         o_q    <= {WIDTH{1'b1}};
      end
      else
      begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end

endmodule

// file: hdl/sbb_buffer_ctrl.sv
// connection control, wired-AND relay and stuck bus recovery of a two-wire bus buffer
`timescale 1ns/100ps

// What this block does
// R01 - during undervoltage lockout ignore both segments and keep them disconnected
// R02 - after lockout wait for backplane stop or idle before connecting
// R03 - idle qualification and enable-to-connect delay last about 95 us
// R04 - connect and raise ready only when both card lines are high, or at once on an R16 enable edge
// R05 - while connected a low on either side is copied to the other side
// R06 - while connected a line returns high only when both sides release it
// R07 - stuck timer runs while a card line is low, clears when both high
// R08 - at the 30 ms timeout break both data and clock connections
// R09 - at least 40 us later drive up to 16 card clock pulses at 8.5 kHz
// R10 - after a stuck disconnect reconnect only through the normal start-up qualification or an R16 enable edge
// R11 - stuck at power-up: stay disconnected, start clocking 30 ms after lockout
// R12 - ready is released only while connected, pulled low otherwise
// R13 - enable low disconnects the segments and pulls ready low
// R14 - enable high waits for backplane idle and card high before connecting
// R15 - automatic clocking is suppressed while enable is low
// R16 - enable rising after a fault connects at once; stuck timer cleared, still running
// R17 - accelerators on only while connected, off during automatic clocking
// R18 - stop is backplane data rising while backplane clock is high, after syncing
// R19 - clocking ends early when both card lines are high between pulses
// R20 - all intervals are counted in clock cycles from parameters
module sbb_buffer_ctrl #(
   parameter int TIMEOUT_CYC = sbb_pkg::TIMEOUT_CYC
) (
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   input  wire logic i_link_clk,
   input  wire logic i_undervoltage_lockout,
   input  wire logic i_enable,
   input  wire logic i_backplane_data,
   input  wire logic i_backplane_clock,
   input  wire logic i_card_data,
   input  wire logic i_card_clock,
   output logic      o_backplane_data,
   output logic      o_backplane_data_oe,
   output logic      o_backplane_clock,
   output logic      o_backplane_clock_oe,
   output logic      o_card_data,
   output logic      o_card_data_oe,
   output logic      o_card_clock,
   output logic      o_card_clock_oe,
   output logic      o_ready,
   output logic      o_ready_oe,
   output logic      o_accel_en
);
   import sbb_pkg::*;

   localparam int TW = 20;

   // the stuck timer width is fixed; refuse a timeout it cannot hold
   if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << TW))
   begin : g_chk
      $error("TIMEOUT_CYC out of range");
   end

   // saturating decrement, used by every hold-off counter
   function automatic logic [3:0] dec_sat(input logic [3:0] v);
      dec_sat = (v == 4'h0) ? 4'h0 : v - 4'h1;
   endfunction

   logic [3:0]      sys_pins;
   logic [1:0]      link_pins;
   logic [1:0]      card_lvl_q;
   logic [1:0]      card_pins;
   logic            undervoltage_lockout_s;
   logic            en_s;
   logic            en_d1_q;
   logic            bp_dat_d1_q;
   logic [1:0]      bp_low;
   logic [1:0]      card_low;
   logic            stop_det;
   logic            en_rise;
   sbb_state_t      state_q;
   sbb_state_t      state_d;
   logic            fault_q;
   logic [TW-1:0]   stuck_q;
   logic            timeout;
   logic [CNT_W-1:0] wait_q;
   logic [CNT_W-1:0] idle_q;
   logic            stop_seen_q;
   logic            qual_ok;
   logic [CNT_W-1:0] gap_q;
   logic [CNT_W-1:0] half_q;
   logic            rec_low_q;
   logic [4:0]      pulse_q;
   logic            half_end;
   logic            rec_done;
   logic [1:0]      bp_drv_q;
   logic [1:0]      bp_drv_d;
   logic [1:0]      card_drv_q;
   logic [1:0]      card_drv_d;
   logic [3:0]      bp_hold_q [2];
   logic [3:0]      card_hold_q [2];
   logic            conn;

   // backplane pins, enable and lockout come from outside this domain
   sbb_sync2 #(
      .WIDTH (4)
   ) u_sys_sync (
      .i_clk   (i_sys_clk),
      .i_rst_n (i_rst_n),
      .i_d     ({i_undervoltage_lockout, i_enable, i_backplane_clock, i_backplane_data}),
      .o_q     (sys_pins)
   );

   // card pins are sampled on the link clock
   sbb_sync2 #(
      .WIDTH (2)
   ) u_link_sync (
      .i_clk   (i_link_clk),
      .i_rst_n (i_rst_n),
      .i_d     ({i_card_clock, i_card_data}),
      .o_q     (link_pins)
   );

   // card levels registered in the link domain before crossing
   always_ff @(posedge i_link_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         card_lvl_q <= 2'h3;
      else
         card_lvl_q <= link_pins;
   end

   // levels only, so each bit may cross on its own pair of flip-flops
   sbb_sync2 #(
      .WIDTH (2)
   ) u_card_cross (
      .i_clk   (i_sys_clk),
      .i_rst_n (i_rst_n),
      .i_d     (card_lvl_q),
      .o_q     (card_pins)
   );

   // reset value of the lockout sync is high, so the block starts locked out
   assign undervoltage_lockout_s   = sys_pins[3];
   assign en_s     = sys_pins[2];
   assign bp_low   = ~sys_pins[1:0];
   assign card_low = ~card_pins;
   assign conn     = (state_q == SBB_CONN);

   // edge history for stop and enable detection; reset values match the syncs'
   // reset level, so no false enable edge follows reset
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bp_dat_d1_q <= 1'b1;
         en_d1_q     <= 1'b1;
      end
      else
      begin
         bp_dat_d1_q <= sys_pins[0];
         en_d1_q     <= en_s;
      end
   end

   assign stop_det = sys_pins[0] & ~bp_dat_d1_q & sys_pins[1]; // R18
   assign en_rise  = en_s & ~en_d1_q;

   // stuck-low timer; cleared with both card lines high, in lockout, in fault handling and on a forced reconnect
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         stuck_q <= '0;
      else if (undervoltage_lockout_s || card_low == 2'h0) // R07
         stuck_q <= '0;
      else if (state_q == SBB_GAP || state_q == SBB_RECOVER)
         stuck_q <= '0;
      else if (en_rise && fault_q) // R16
         stuck_q <= '0;
      else if (!timeout)
         stuck_q <= stuck_q + 1'b1; // R07 R11 R20
   end

   assign timeout = (stuck_q == TW'(TIMEOUT_CYC - 1));

   // start-up qualification: enable delay, idle time and stop capture
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wait_q      <= '0;
         idle_q      <= '0;
         stop_seen_q <= 1'b0;
      end
      else if (state_q != SBB_WAIT_BUS || !en_s)
      begin
         wait_q      <= '0;
         idle_q      <= '0;
         stop_seen_q <= 1'b0;
      end
      else
      begin
         if (wait_q != CNT_W'(IDLE_CYC))
            wait_q <= wait_q + 1'b1; // R03
         if (bp_low != 2'h0)
            idle_q <= '0;
         else if (idle_q != CNT_W'(IDLE_CYC))
            idle_q <= idle_q + 1'b1; // R03
         if (stop_det)
            stop_seen_q <= 1'b1; // R02
      end
   end

   // a stop alone still waits out the enable-to-connect delay
   assign qual_ok = (wait_q == CNT_W'(IDLE_CYC))
                  && (stop_seen_q || idle_q == CNT_W'(IDLE_CYC)); // R02 R03 R14

   // recovery timing: gap before clocking, then half periods
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         gap_q <= '0;
      else if (state_q != SBB_GAP)
         gap_q <= '0;
      else if (gap_q != CNT_W'(GAP_CYC))
         gap_q <= gap_q + 1'b1; // R09
   end

   assign half_end = (half_q == CNT_W'(REC_HALF_CYC - 1));
   // only checked at the end of a high phase, i.e. between pulses
   assign rec_done = half_end && !rec_low_q
                   && (card_low == 2'h0 || pulse_q == 5'(REC_PULSES)); // R19 R09

   // pulse generator: low phase first, a pulse counted on each release
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         half_q    <= '0;
         rec_low_q <= 1'b0;
         pulse_q   <= '0;
      end
      else if (state_q != SBB_RECOVER)
      begin
         half_q    <= '0;
         rec_low_q <= (state_d == SBB_RECOVER);
         pulse_q   <= '0;
      end
      else if (half_end)
      begin
         half_q    <= '0;
         rec_low_q <= ~rec_low_q && !rec_done;
         if (rec_low_q)
            pulse_q <= pulse_q + 5'h1;
      end
      else
         half_q <= half_q + 1'b1;
   end

   // connection state machine
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         SBB_LOCK:
            state_d = SBB_WAIT_BUS;
         SBB_WAIT_BUS:
            if (timeout)
               state_d = SBB_GAP; // R11
            else if (en_rise && fault_q)
               state_d = SBB_CONN; // R16
            else if (en_s && qual_ok)
               state_d = SBB_WAIT_CARD; // R02 R14
         SBB_WAIT_CARD:
            if (timeout)
               state_d = SBB_GAP;
            else if (!en_s)
               state_d = SBB_WAIT_BUS; // R13
            else if (card_low == 2'h0)
               state_d = SBB_CONN; // R04
         SBB_CONN:
            if (!en_s)
               state_d = SBB_WAIT_BUS; // R13
            else if (timeout)
               state_d = SBB_GAP; // R08
         SBB_GAP:
            if (en_rise && fault_q)
               state_d = SBB_CONN; // R16
            else if (gap_q == CNT_W'(GAP_CYC) && en_s)
               state_d = SBB_RECOVER; // R09 R15
         SBB_RECOVER:
            if (!en_s)
               state_d = SBB_WAIT_BUS; // R15
            else if (rec_done)
               state_d = SBB_WAIT_BUS; // R10
         default:
            state_d = SBB_LOCK;
      endcase
      if (undervoltage_lockout_s)
         state_d = SBB_LOCK; // R01
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state_q <= SBB_LOCK;
      else
         state_q <= state_d;
   end

   // fault memory for the forced reconnect on an enable edge
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         fault_q <= 1'b0;
      else if (undervoltage_lockout_s || state_d == SBB_CONN)
         fault_q <= 1'b0;
      else if (timeout && state_q != SBB_LOCK)
         fault_q <= 1'b1;
   end

   // relay: drive a side only for a low that someone else makes on the other side;
   // a side already low is not driven, so two outside lows cannot latch each other
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         bp_drv_d[c] = conn && card_low[c] && !card_drv_q[c]
                     && card_hold_q[c] == 4'h0
                     && (!bp_low[c] || bp_drv_q[c]); // R05 R06
         card_drv_d[c] = conn && bp_low[c] && !bp_drv_q[c]
                       && bp_hold_q[c] == 4'h0
                       && (!card_low[c] || card_drv_q[c]); // R05 R06
      end
      card_drv_d[1] = card_drv_d[1] || (state_d == SBB_RECOVER && rec_low_q); // R09
      if (state_d == SBB_RECOVER && half_end && rec_low_q)
         card_drv_d[1] = 1'b0;
   end

   // drive registers and hold-off after our own release (sync latency)
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bp_drv_q   <= 2'h0;
         card_drv_q <= 2'h0;
         for (int c = 0; c < 2; c++)
         begin
            bp_hold_q[c]   <= 4'h0;
            card_hold_q[c] <= 4'h0;
         end
      end
      else
      begin
         bp_drv_q   <= bp_drv_d;
         card_drv_q <= card_drv_d;
         for (int c = 0; c < 2; c++)
         begin
            bp_hold_q[c]   <= (bp_drv_q[c] && !bp_drv_d[c]) ? 4'(HOLD_CYC)
                                                           : dec_sat(bp_hold_q[c]);
            card_hold_q[c] <= (card_drv_q[c] && !card_drv_d[c]) ? 4'(HOLD_CYC)
                                                               : dec_sat(card_hold_q[c]);
         end
      end
   end

   assign o_backplane_data_oe  = bp_drv_q[0];
   assign o_backplane_clock_oe = bp_drv_q[1];
   assign o_card_data_oe       = card_drv_q[0];
   assign o_card_clock_oe      = card_drv_q[1];

   // status outputs follow the next state so they move with the connection
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_ready_oe <= 1'b1;
         o_accel_en <= 1'b0;
      end
      else
      begin
         o_ready_oe <= (state_d != SBB_CONN); // R12 R13
         o_accel_en <= (state_d == SBB_CONN); // R17
      end
   end

   // open-drain data values are always low; only the enables move
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_backplane_data  <= 1'b0;
         o_backplane_clock <= 1'b0;
         o_card_data       <= 1'b0;
         o_card_clock      <= 1'b0;
         o_ready           <= 1'b0;
      end
      else
      begin
         o_backplane_data  <= 1'b0;
         o_backplane_clock <= 1'b0;
         o_card_data       <= 1'b0;
         o_card_clock      <= 1'b0;
         o_ready           <= 1'b0;
      end
   end

endmodule

// file: verification/sbb_buffer_ctrl_sva.sv
// concurrent checks on the ports of the stuck bus buffer control
`timescale 1ns/100ps
module sbb_buffer_ctrl_sva
   import sbb_pkg::*;
#(
   parameter int TIMEOUT_CYC = sbb_pkg::TIMEOUT_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_undervoltage_lockout,
   input wire logic i_enable,
   input wire logic i_backplane_data,
   input wire logic i_backplane_clock,
   input wire logic i_card_data,
   input wire logic i_card_clock,
   input wire logic o_backplane_data_oe,
   input wire logic o_backplane_clock_oe,
   input wire logic o_card_data_oe,
   input wire logic o_card_clock_oe,
   input wire logic o_ready_oe,
   input wire logic o_accel_en
);
   logic [15:0] en_q;
   logic [19:0] stk_q;
   logic [15:0] pul_q;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   // enable age, stuck age while joined, width of a recovery pulse
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         en_q <= 16'h0;
         stk_q <= 20'h0;
         pul_q <= 16'h0;
      end
      else
      begin
         en_q <= !i_enable ? 16'h0 : (en_q == 16'hFFFF ? en_q : en_q + 16'h1);
         stk_q <= (o_accel_en && !(i_card_data && i_card_clock)) ? stk_q + 20'h1 : 20'h0;
         pul_q <= (o_card_clock_oe && !o_accel_en) ? pul_q + 16'h1 : 16'h0;
      end
   end

   property p_lock; i_undervoltage_lockout[*5] |-> o_ready_oe && !o_card_data_oe; endproperty
   property p_ready; o_accel_en == !o_ready_oe; endproperty
   property p_en_off; !i_enable[*6] |-> o_ready_oe && !o_card_clock_oe; endproperty
   property p_relay_bp;
      (o_accel_en && !i_backplane_data && !o_backplane_data_oe && i_card_data)[*3]
         |-> ##[0:2] o_card_data_oe;
   endproperty
   property p_relay_ck;
      (o_accel_en && !i_card_clock && !o_card_clock_oe && i_backplane_clock)[*3]
         |-> ##[0:12] o_backplane_clock_oe;
   endproperty
   property p_hold;
      o_card_data_oe && !i_backplane_data && !o_backplane_data_oe && o_accel_en
         |=> o_card_data_oe;
   endproperty
   property p_release; o_card_data_oe && i_backplane_data |-> ##[1:6] !o_card_data_oe; endproperty
   property p_stuck; stk_q < 20'(TIMEOUT_CYC + 40); endproperty
   property p_idle; $rose(o_accel_en) |-> en_q >= 16'(IDLE_CYC) || en_q < 16'd10; endproperty
   property p_pulse;
      $fell(o_card_clock_oe) && !o_accel_en && i_enable |-> pul_q inside {[1469:1471]};
   endproperty

   a_lock: assert property (p_lock)
      else $error("lockout left a connection");
   a_ready: assert property (p_ready)
      else $error("ready and accelerator disagree");
   a_en_off: assert property (p_en_off)
      else $error("enable low left link or clocking on");
   a_relay_bp: assert property (p_relay_bp)
      else $error("backplane low not copied to card");
   a_relay_ck: assert property (p_relay_ck)
      else $error("card clock low not copied to backplane");
   a_hold: assert property (p_hold)
      else $error("card released while backplane low");
   a_release: assert property (p_release)
      else $error("card held after backplane release");
   a_stuck: assert property (p_stuck)
      else $error("stuck bus not disconnected");
   a_idle: assert property (p_idle)
      else $error("connected before idle delay");
   a_pulse: assert property (p_pulse)
      else $error("recovery pulse width wrong");

   c_conn: cover property ($rose(o_accel_en));
   c_pulse: cover property ($fell(o_card_clock_oe) && !o_accel_en);
   c_drop: cover property ($rose(o_ready_oe) && i_enable);
endmodule

bind sbb_buffer_ctrl sbb_buffer_ctrl_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) sva_i (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_undervoltage_lockout(i_undervoltage_lockout),
   .i_enable(i_enable), .i_backplane_data(i_backplane_data),
   .i_backplane_clock(i_backplane_clock), .i_card_data(i_card_data),
   .i_card_clock(i_card_clock), .o_backplane_data_oe(o_backplane_data_oe),
   .o_backplane_clock_oe(o_backplane_clock_oe), .o_card_data_oe(o_card_data_oe),
   .o_card_clock_oe(o_card_clock_oe), .o_ready_oe(o_ready_oe), .o_accel_en(o_accel_en));

// file: verification/sbb_bus_model.sv
// bus devices on both segments, resolving each open-drain wire with its pull-up
`timescale 1ns/100ps
module sbb_bus_model (
   input  wire logic       i_sys_clk,
   input  wire logic [3:0] i_dut_oe,   // backplane data, clock, card data, clock
   input  wire logic [3:0] i_pull,     // outside drivers, same order
   input  wire logic [4:0] i_stick,    // clock rises a stuck card device needs
   input  wire logic       i_stick_go,
   output logic      [3:0] o_wire
);
   logic [4:0] left_q = 5'h0;
   logic       ck_q = 1'b1;
   // a released wire floats up through its pull-up
   assign o_wire = ~(i_dut_oe | i_pull | {2'b00, left_q != 5'h0, 1'b0});
   // the stuck device lets go of data only after enough card clock rises
   always_ff @(posedge i_sys_clk)
   begin
      ck_q <= o_wire[0];
      if (i_stick_go)
         left_q <= i_stick;
      else if (o_wire[0] && !ck_q && left_q != 5'h0)
         left_q <= left_q - 5'h1;
   end
endmodule

// file: verification/tb_top.sv
// self-checking bench for the stuck bus buffer control
`timescale 1ns/100ps
module tb_top;
   import sbb_pkg::*;
   localparam int TMO = 3000;
   logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, undervoltage_lockout = 1'b1, en = 1'b0, go = 1'b0;
   logic [3:0] pull = 4'h0;
   logic [3:0] oe, w;
   logic [4:0] stick = 5'h0;
   logic rdy_oe, accel;
   logic [4:0] vals;
   logic [31:0] seed = 32'h7AE0F694;
   int miscompares = 0, cmp_count = 0, n, t;

   initial forever #20 clk = ~clk;
   // link clock free-running, phase unrelated to the system clock
   initial
   begin
      #7;
      forever #32 lclk = ~lclk;
   end

   sbb_buffer_ctrl #(.TIMEOUT_CYC(TMO)) sbb_buffer_ctrl_i (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_undervoltage_lockout(undervoltage_lockout),
      .i_enable(en), .i_backplane_data(w[3]), .i_backplane_clock(w[2]),
      .i_card_data(w[1]), .i_card_clock(w[0]), .o_backplane_data(vals[3]),
      .o_backplane_data_oe(oe[3]), .o_backplane_clock(vals[2]), .o_backplane_clock_oe(oe[2]),
      .o_card_data(vals[1]), .o_card_data_oe(oe[1]),
      .o_card_clock(vals[0]), .o_card_clock_oe(oe[0]),
      .o_ready(vals[4]), .o_ready_oe(rdy_oe), .o_accel_en(accel));

   sbb_bus_model sbb_bus_model_i (.i_sys_clk(clk), .i_dut_oe(oe), .i_pull(pull),
      .i_stick(stick), .i_stick_go(go), .o_wire(w));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   function automatic logic in_rng(input int v, input int lo, input int hi);
      return v >= lo && v <= hi;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s exp %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      if (miscompares == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // cycles until the ready pull-down reaches the given level, bounded
   task automatic wait_rdy(input logic lvl, output int c);
      c = 0;
      while (rdy_oe !== lvl && c < 60000)
      begin
         @(negedge clk);
         c++;
      end
   endtask

   // time to first recovery pulse, then pulses until the clocking goes quiet
   task automatic recover(output int first, output int pulses);
      int idle;
      logic prev;
      first = 0;
      pulses = 0;
      idle = 0;
      prev = 1'b0;
      while (oe[0] !== 1'b1 && first < 8000)
      begin
         @(negedge clk);
         first++;
      end
      while (idle < 3200)
      begin
         if (oe[0] === 1'b1 && !prev)
         begin
            pulses++;
            idle = 0;
         end
         else
            idle++;
         prev = oe[0];
         @(negedge clk);
      end
   endtask

   initial
   begin
      // power up into a stuck card bus with the backplane busy
      stick = 5'h3;
      go = 1'b1;
      pull = 4'h8;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      go = 1'b0;
      en = 1'b1;
      repeat (50) @(negedge clk);
      check("lock_ready", rdy_oe, 1'b1);
      check("lock_relay", oe[1], 1'b0);
      undervoltage_lockout = 1'b0;
      pull = 4'h0;
      recover(t, n);
      check("boot_first", in_rng(t, TMO + GAP_CYC, TMO + GAP_CYC + 30), 1'b1);
      check("boot_pulses", n, 32'h3);
      wait_rdy(1'b0, t);
      check("boot_conn", in_rng(t, IDLE_CYC - 300, IDLE_CYC - 200), 1'b1);
      // random single-line lows from either side while joined
      for (int i = 0; i < 16; i++)
      begin
         seed = xs(seed);
         pull = 4'h1 << seed[1:0];
         repeat (14) @(negedge clk);
         check("relay_low", oe[seed[1:0] ^ 2'h2], 1'b1);
         pull = 4'h0;
         repeat (40) @(negedge clk);
         check("relay_rel", w, 4'hF);
         repeat (seed[6:2]) @(negedge clk);
      end
      // enable low, then a bus that sticks while disabled
      en = 1'b0;
      repeat (5) @(negedge clk);
      check("en_off", rdy_oe, 1'b1);
      check("accel_off", accel, 1'b0);
      stick = 5'h14;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      t = 0;
      repeat (TMO + GAP_CYC + 500)
      begin
         @(negedge clk);
         t += oe[0];
      end
      check("en_off_clk", t, 32'h0);
      en = 1'b1;
      repeat (8) @(negedge clk);
      check("forced", rdy_oe, 1'b0);
      check("accel_on", accel, 1'b1);
      check("od_vals", vals, 5'h0);
      wait_rdy(1'b1, t);
      check("stuck_tmo", in_rng(t, TMO - 10, TMO + 20), 1'b1);
      recover(t, n);
      check("gap", in_rng(t, GAP_CYC, GAP_CYC + 5), 1'b1);
      check("pulses", n, REC_PULSES);
      check("still_stuck", rdy_oe, 1'b1);
      // card freed, backplane busy; a stop ends the wait long before an idle could
      stick = 5'h0;
      go = 1'b1;
      pull = 4'h8;
      @(negedge clk);
      go = 1'b0;
      repeat (1000) @(negedge clk);
      pull = 4'h0;
      wait_rdy(1'b0, t);
      check("reconnect", in_rng(t, IDLE_CYC - 1300, IDLE_CYC - 1200), 1'b1);
      stop_test;
   end

   // cut a hang short well past the expected run length
   initial
   begin
      repeat (90000) @(posedge clk);
      miscompares++;
      stop_test;
   end
endmodule
